// [core/prd_pkg.sv]
// Pipelined request decoder package: command codes, field layout, request record.
// Assumes a single bus clock domain shared by all users.
package prd_pkg;
  localparam int          CMD_W       = 4;
  localparam int          LEN_W       = 3;
  localparam int          ADDR_W      = 64;
  localparam int          QWC_W       = 6;
  localparam int          SEQ_W       = 8;
  localparam int          SLOT_W      = 9;
  localparam logic [8:0]  MAX_SLOTS   = 9'h100;
  localparam int          LONG_SHIFT  = 2;
  localparam int          UPPER_LSB   = 32;
  localparam logic [3:0]  CMD_RD      = 4'h0;
  localparam logic [3:0]  CMD_RD_HP   = 4'h1;
  localparam logic [3:0]  CMD_WR      = 4'h4;
  localparam logic [3:0]  CMD_WR_HP   = 4'h5;
  localparam logic [3:0]  CMD_LRD     = 4'h8;
  localparam logic [3:0]  CMD_LRD_HP  = 4'h9;
  localparam logic [3:0]  CMD_FLUSH   = 4'ha;
  localparam logic [3:0]  CMD_FENCE   = 4'hc;
  localparam logic [3:0]  CMD_DUAL    = 4'hd;
  localparam logic [5:0]  QWC_ONE     = 6'h01;

  typedef enum logic [1:0] {
    PRD_KIND_READ,
    PRD_KIND_WRITE,
    PRD_KIND_FLUSH,
    PRD_KIND_FENCE
  } prd_kind_e;

  typedef struct packed {
    prd_kind_e         kind;
    logic              high_priority;
    logic              long_read;
    logic [63:3]       addr;
    logic [QWC_W-1:0]  qw_count;
    logic [SEQ_W-1:0]  seq;
  } prd_req_s;

  // Quadword count: length_field plus one, times four for a long read
  function automatic logic [QWC_W-1:0] qw_count(input logic [LEN_W-1:0] len,
                                                input logic            is_long);
    logic [QWC_W-1:0] n;
    n = {3'h0, len} + QWC_ONE;
    return is_long ? QWC_W'(n << LONG_SHIFT) : n;
  endfunction : qw_count
endpackage : prd_pkg

// [core/prd_req_if.sv]
// Valid/ready carrier for decoded requests between the decoder's own modules.
// Assumes source and sink share the bus clock.
`timescale 1ns/1ps
`default_nettype none
interface prd_req_if;
  logic              valid;
  logic              ready;
  prd_pkg::prd_req_s data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : prd_req_if
`default_nettype wire

// [core/prd_cmd_dec.sv]
// Command field decoder: classifies the four-bit command.
// Assumes the command is already sampled in the bus clock domain.
`timescale 1ns/1ps
`default_nettype none
module prd_cmd_dec (
  input  wire logic [3:0]        i_cmd,
  input  wire logic              i_sideband,
  output var  prd_pkg::prd_kind_e o_kind,
  output logic                   o_high_priority,
  output logic                   o_long_read,
  output logic                   o_dual,
  output logic                   o_reserved
);
  always_comb begin
    o_kind          = prd_pkg::PRD_KIND_READ;
    o_high_priority = 1'b0;
    o_long_read     = 1'b0;
    o_dual          = 1'b0;
    o_reserved      = 1'b0;
    case (i_cmd)
      prd_pkg::CMD_RD: ;
      prd_pkg::CMD_RD_HP: o_high_priority = 1'b1;
      prd_pkg::CMD_WR: o_kind = prd_pkg::PRD_KIND_WRITE;
      prd_pkg::CMD_WR_HP: begin
        o_kind          = prd_pkg::PRD_KIND_WRITE;
        o_high_priority = 1'b1;
      end
      prd_pkg::CMD_LRD: o_long_read = 1'b1;
      prd_pkg::CMD_LRD_HP: begin
        o_long_read     = 1'b1;
        o_high_priority = 1'b1;
      end
      prd_pkg::CMD_FLUSH: o_kind = prd_pkg::PRD_KIND_FLUSH;
      prd_pkg::CMD_FENCE: o_kind = prd_pkg::PRD_KIND_FENCE;
      prd_pkg::CMD_DUAL: begin
        // Not valid when requests come through the sideband port
        o_dual     = ~i_sideband;
        o_reserved = i_sideband;
      end
      default: o_reserved = 1'b1;
    endcase
  end
endmodule : prd_cmd_dec
`default_nettype wire

// [core/prd_buf2.sv]
// Two-entry request buffer with valid/ready on both sides.
// Assumes one clock; the drain side may hold ready low for any time.
`timescale 1ns/1ps
`default_nettype none
module prd_buf2 #(
  parameter int DEPTH = 2
) (
  input  wire logic  i_clk,
  input  wire logic  i_resetn,
  prd_req_if.sink    in_p,
  prd_req_if.source  out_p
);
  localparam int PW = $clog2(DEPTH);
  prd_pkg::prd_req_s  mem [DEPTH];
  logic [PW-1:0]      wr_ptr_r;
  logic [PW-1:0]      rd_ptr_r;
  logic [PW:0]        count_r;
  logic               push;
  logic               pop;

  assign in_p.ready  = (count_r != (PW+1)'(DEPTH));
  assign out_p.valid = (count_r != '0);
  assign out_p.data  = mem[rd_ptr_r];
  assign push        = in_p.valid & in_p.ready;
  assign pop         = out_p.valid & out_p.ready;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : inc

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_p.data;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= inc(rd_ptr_r);
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : prd_buf2
`default_nettype wire

// [core/prd_top.sv]
// Target-side decoder for pipelined access requests on the multiplexed bus.
// Assumes bus pins are synchronous to I_SYS_CLK (the shared bus clock).
// Contract
// - Ordering follows request arrival, not data
// - Requests address main system memory only
// - Eight-byte aligned, whole quadword lengths
// - No processor cache snoop needed
// - Command sampled from byte-enable lines
// - Low three address bits hold length
// - Command codes decode per fixed table
// - Read returns length plus one quadwords
// - Long read moves four times that
// - Write stores enabled bytes, may pass reads
// - High-priority reads use separate queue
// - High-priority write ordered among high only
// - Flush drains writes, returns one quadword
// - Fence marks boundary, uses no slot
// - Dual address takes two request clocks
// - Dual address reserved on sideband port
// - Requests framed by pipe strobe
`timescale 1ns/1ps
`default_nettype none
module prd_top (
  input  wire logic                   I_SYS_CLK,
  input  wire logic                   I_RESETN,
  input  wire logic                   I_PIPE_N,
  input  wire logic [31:0]            I_AD,
  input  wire logic [3:0]             I_CBE_N,
  input  wire logic                   I_SIDEBAND,
  input  wire logic                   I_SLOT_RETIRE,
  input  wire logic                   I_REQ_READY,
  output logic                        O_REQ_VALID,
  output var  prd_pkg::prd_kind_e     O_REQ_KIND,
  output logic                        O_REQ_HIGH_PRIORITY,
  output logic                        O_REQ_LONG,
  output logic [63:3]                 O_REQ_ADDR,
  output logic [prd_pkg::QWC_W-1:0]   O_REQ_QW_COUNT,
  output logic [prd_pkg::SEQ_W-1:0]   O_REQ_SEQ,
  output logic                        O_REQ_STALL,
  output logic [prd_pkg::SLOT_W-1:0]  O_SLOTS_USED,
  output logic                        O_PROTOCOL_ERROR
);
  typedef enum logic {
    PRD_ST_ADDR,
    PRD_ST_UPPER
  } prd_state_e;

  prd_state_e                 state_r;
  prd_state_e                 state_nxt;
  logic                       pipe_r;
  logic [31:0]                ad_r;
  logic [3:0]                 cmd_r;
  logic [31:3]                low_addr_r;
  logic [2:0]                 low_len_r;
  prd_pkg::prd_req_s          req_r;
  logic                       req_valid_r;
  logic [prd_pkg::SEQ_W-1:0]  seq_r;
  logic [prd_pkg::SLOT_W-1:0] slots_r;
  logic                       err_r;
  prd_pkg::prd_kind_e         d_kind;
  logic                       d_hp;
  logic                       d_long;
  logic                       d_dual;
  logic                       d_rsvd;
  logic                       emit;
  logic                       emit_upper;
  logic                       bad;
  logic                       take;
  logic                       slot_take;

  prd_req_if buf_in ();
  prd_req_if buf_out ();

  // Pins share the bus clock, so one register stage is for timing only
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pipe_r <= 1'b0;
      ad_r   <= 32'h0000_0000;
      cmd_r  <= 4'h0;
    end else begin
      pipe_r <= ~I_PIPE_N;
      ad_r   <= I_AD;
      cmd_r  <= I_CBE_N;
    end
  end

  prd_cmd_dec u_dec (
    .i_cmd           (cmd_r),
    .i_sideband      (I_SIDEBAND),
    .o_kind          (d_kind),
    .o_high_priority (d_hp),
    .o_long_read     (d_long),
    .o_dual          (d_dual),
    .o_reserved      (d_rsvd)
  );

  // Request framing and the two-clock dual address sequence
  always_comb begin
    state_nxt  = state_r;
    emit       = 1'b0;
    emit_upper = 1'b0;
    bad        = 1'b0;
    case (state_r)
      PRD_ST_ADDR: begin
        if (pipe_r) begin
          if (d_dual) begin
            state_nxt = PRD_ST_UPPER;
          end else if (d_rsvd) begin
            bad = 1'b1;
          end else begin
            emit = 1'b1;
          end
        end
      end
      PRD_ST_UPPER: begin
        state_nxt = PRD_ST_ADDR;
        if (!pipe_r || d_dual || d_rsvd) begin
          // Broken second clock: drop the whole request
          bad = 1'b1;
        end else begin
          emit       = 1'b1;
          emit_upper = 1'b1;
        end
      end
      default: state_nxt = PRD_ST_ADDR;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_r <= PRD_ST_ADDR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // First clock of a dual address request keeps low address and length
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      low_addr_r <= '0;
      low_len_r  <= 3'h0;
    end else if (state_r == PRD_ST_ADDR && pipe_r && d_dual) begin
      low_addr_r <= ad_r[31:3];
      low_len_r  <= ad_r[2:0];
    end
  end

  // Request record; low three bits are length, so aligned by construction
  function automatic prd_pkg::prd_req_s build(input logic [31:0] upper,
                                              input logic [31:3] lower,
                                              input logic [2:0]  len,
                                              input logic [prd_pkg::SEQ_W-1:0] seq);
    prd_pkg::prd_req_s r;
    r               = '0;
    r.kind          = d_kind;
    r.high_priority = d_hp;
    r.long_read     = d_long;
    r.addr          = {upper, lower};
    r.seq           = seq;
    if (d_kind == prd_pkg::PRD_KIND_FLUSH) begin
      r.addr     = '0;
      r.qw_count = prd_pkg::QWC_ONE;
    end else if (d_kind == prd_pkg::PRD_KIND_FENCE) begin
      r.addr     = '0;
      r.qw_count = '0;
    end else begin
      r.qw_count = prd_pkg::qw_count(len, d_long);
    end
    return r;
  endfunction : build

  // One holding stage feeds the buffer; a full buffer raises stall
  assign take      = emit && !(req_valid_r && !buf_in.ready);
  assign slot_take = take && (d_kind != prd_pkg::PRD_KIND_FENCE);

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      req_valid_r <= 1'b0;
      req_r       <= '0;
    end else if (take) begin
      req_valid_r <= 1'b1;
      if (emit_upper) begin
        req_r <= build(ad_r, low_addr_r, low_len_r, seq_r);
      end else begin
        req_r <= build(32'h0000_0000, ad_r[31:3], ad_r[2:0], seq_r);
      end
    end else if (buf_in.ready) begin
      req_valid_r <= 1'b0;
    end
  end

  // Arrival stamp lets the memory side order by request, not by data
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      seq_r <= '0;
    end else if (take) begin
      seq_r <= prd_pkg::SEQ_W'(seq_r + 1'b1);
    end
  end

  // Outstanding slot count; a fence takes none
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      slots_r <= '0;
    end else if (slot_take && !(I_SLOT_RETIRE && slots_r != '0)) begin
      slots_r <= prd_pkg::SLOT_W'(slots_r + 1'b1);
    end else if (!slot_take && I_SLOT_RETIRE && slots_r != '0) begin
      slots_r <= prd_pkg::SLOT_W'(slots_r - 1'b1);
    end
  end

  // Error pulse: reserved code, broken dual address, overrun or slot excess
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      err_r <= 1'b0;
    end else begin
      err_r <= bad || (emit && !take)
            || (slot_take && slots_r >= prd_pkg::MAX_SLOTS);
    end
  end

  assign buf_in.valid = req_valid_r;
  assign buf_in.data  = req_r;

  // Read, write and high-priority queues sit downstream; the buffer
  // with the holding stage absorbs three requests of a receiver stall; a further one is dropped. No snoop path exists.
  prd_buf2 #(
    .DEPTH (2)
  ) u_buf (
    .i_clk    (I_SYS_CLK),
    .i_resetn (I_RESETN),
    .in_p     (buf_in),
    .out_p    (buf_out)
  );

  assign buf_out.ready       = I_REQ_READY;
  assign O_REQ_VALID         = buf_out.valid;
  assign O_REQ_KIND          = buf_out.data.kind;
  assign O_REQ_HIGH_PRIORITY = buf_out.data.high_priority;
  assign O_REQ_LONG          = buf_out.data.long_read;
  assign O_REQ_ADDR          = buf_out.data.addr;
  assign O_REQ_QW_COUNT      = buf_out.data.qw_count;
  assign O_REQ_SEQ           = buf_out.data.seq;
  assign O_REQ_STALL         = ~buf_in.ready;
  assign O_SLOTS_USED        = slots_r;
  assign O_PROTOCOL_ERROR    = err_r;
endmodule : prd_top
`default_nettype wire

// [bench/prd_chk.sv]
// Concurrent checks on the decoder top-level ports.
// Assumes one bus clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module prd_chk (
  input wire logic                      I_SYS_CLK,
  input wire logic                      I_RESETN,
  input wire logic                      I_PIPE_N,
  input wire logic [3:0]                I_CBE_N,
  input wire logic                      I_SLOT_RETIRE,
  input wire logic                      I_REQ_READY,
  input wire logic                      O_REQ_VALID,
  input wire prd_pkg::prd_kind_e        O_REQ_KIND,
  input wire logic                      O_REQ_LONG,
  input wire logic [63:3]               O_REQ_ADDR,
  input wire logic [prd_pkg::QWC_W-1:0] O_REQ_QW_COUNT,
  input wire logic [prd_pkg::SEQ_W-1:0] O_REQ_SEQ,
  input wire logic                      O_REQ_STALL,
  input wire logic [prd_pkg::SLOT_W-1:0] O_SLOTS_USED,
  input wire logic                      O_PROTOCOL_ERROR
);
  logic tk;
  logic rsv;
  logic slot_req;
  assign tk  = O_REQ_VALID && I_REQ_READY;
  assign rsv = I_CBE_N inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hb, 4'he, 4'hf};
  // Slots are taken when a request enters, one clock before the consumer sees it
  assign slot_req = !I_PIPE_N && !rsv && I_CBE_N != prd_pkg::CMD_FENCE
                 && I_CBE_N != prd_pkg::CMD_DUAL;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  AST_FENCE_QW: assert property (O_REQ_VALID && O_REQ_KIND == prd_pkg::PRD_KIND_FENCE
    |-> O_REQ_QW_COUNT == 6'h00) else $error("fence entry with nonzero count");
  AST_FLUSH: assert property (O_REQ_VALID && O_REQ_KIND == prd_pkg::PRD_KIND_FLUSH
    |-> O_REQ_QW_COUNT == 6'h01 && O_REQ_ADDR == 61'h0) else $error("flush entry malformed");
  AST_LONG: assert property (O_REQ_VALID && O_REQ_LONG
    |-> O_REQ_KIND == prd_pkg::PRD_KIND_READ && O_REQ_QW_COUNT[1:0] == 2'h0)
    else $error("long read count not a multiple of four");
  AST_STAND: assert property (O_REQ_VALID && !I_REQ_READY
    |=> O_REQ_VALID && $stable(O_REQ_ADDR) && $stable(O_REQ_SEQ)) else $error("entry moved");
  AST_RSV: assert property (!I_PIPE_N && rsv
    && !($past(I_PIPE_N) == 1'b0 && $past(I_CBE_N) == prd_pkg::CMD_DUAL)
    |-> ##2 O_PROTOCOL_ERROR) else $error("reserved code not flagged");
  AST_SLOT_INC: assert property (slot_req ##1 (!I_SLOT_RETIRE && !O_REQ_STALL
    && O_SLOTS_USED < 9'h100)
    |=> O_SLOTS_USED == $past(O_SLOTS_USED) + 9'h001) else $error("slot not taken");
  AST_SLOT_FENCE: assert property (!I_PIPE_N && I_CBE_N == prd_pkg::CMD_FENCE
    ##1 !I_SLOT_RETIRE |=> $stable(O_SLOTS_USED)) else $error("fence took a slot");
  AST_RETIRE: assert property (I_SLOT_RETIRE && $past(I_PIPE_N) && O_SLOTS_USED != 9'h000
    |=> O_SLOTS_USED == $past(O_SLOTS_USED) - 9'h001) else $error("slot not freed");
  AST_SLOT_MAX: assert property (O_SLOTS_USED <= prd_pkg::MAX_SLOTS)
    else $error("slot count above limit");
  AST_STALL: assert property (O_REQ_STALL |-> O_REQ_VALID)
    else $error("stall with empty buffer");
  cover property (tk && O_REQ_KIND == prd_pkg::PRD_KIND_FENCE);
  cover property (tk && O_REQ_LONG);
  cover property (O_REQ_STALL);
  cover property (O_PROTOCOL_ERROR);
endmodule : prd_chk
`default_nettype wire

// [bench/prd_master.sv]
// Bus master model: frames requests on the pipe strobe.
// Assumes the strobe has a pull-up; bus lines show inverted data when released.
`timescale 1ns/1ps
`default_nettype none
module prd_master (
  input  wire logic        i_clk,
  output logic             o_pipe_n,
  output logic [31:0]      o_ad,
  output logic [3:0]       o_cbe_n
);
  initial begin
    o_pipe_n = 1'b1;
    o_ad     = 32'h0;
    o_cbe_n  = 4'h0;
  end
  // Released lines flip so a stale value never reads as valid
  task automatic put(input logic [31:0] ad, input logic [3:0] c, input logic last);
    @(posedge i_clk);
    o_pipe_n <= 1'b0;
    o_ad     <= ad;
    o_cbe_n  <= c;
    if (last) begin
      @(posedge i_clk);
      o_pipe_n <= 1'b1;
      o_ad     <= ~ad;
      o_cbe_n  <= ~c;
    end
  endtask : put
  // Address from bit 3 up only, so always quadword aligned; no sub-quadword reads
  task automatic req(input logic [3:0] c, input logic [31:3] a, input logic [2:0] l,
                     input logic last);
    put({a, l}, c, last);
  endtask : req
  task automatic dac(input logic [3:0] c, input logic [63:3] a, input logic [2:0] l,
                     input logic last);
    put({a[31:3], l}, prd_pkg::CMD_DUAL, 1'b0);
    put(a[63:32], c, last);
  endtask : dac
endmodule : prd_master
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the request decoder top.
// Assumes the master model drives the bus pins; the bench is the consumer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rstn, sb, rdy, ret, fresh, vld, hp, lng, stall, perr;
  wire logic          pipe_n;
  wire logic [31:0]   ad;
  wire logic [3:0]    cbe_n;
  prd_pkg::prd_kind_e kind;
  logic [63:3]        addr;
  logic [5:0]         qwc;
  logic [7:0]         seq, lseq;
  logic [8:0]         slots;
  int                 err_total, cmp_count, nerr;
  prd_pkg::prd_req_s  got[$];
  prd_top u_prd_top (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_PIPE_N(pipe_n), .I_AD(ad),
    .I_CBE_N(cbe_n), .I_SIDEBAND(sb), .I_SLOT_RETIRE(ret), .I_REQ_READY(rdy),
    .O_REQ_VALID(vld), .O_REQ_KIND(kind), .O_REQ_HIGH_PRIORITY(hp), .O_REQ_LONG(lng),
    .O_REQ_ADDR(addr), .O_REQ_QW_COUNT(qwc), .O_REQ_SEQ(seq), .O_REQ_STALL(stall),
    .O_SLOTS_USED(slots), .O_PROTOCOL_ERROR(perr));
  prd_master u_prd_master (.i_clk(clk), .o_pipe_n(pipe_n), .o_ad(ad), .o_cbe_n(cbe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Consumer side: sampled mid-cycle, taken at the following edge
  always @(negedge clk) begin
    if (vld === 1'b1 && rdy === 1'b1) got.push_back('{kind, hp, lng, addr, qwc, seq});
    if (perr === 1'b1) nerr++;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e, input string m);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic stop_test;
    $display("Mismatches %0d of %0d checks", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic wait_n(input int n);
    for (int i = 0; i < 60 && got.size() < n; i++) @(posedge clk);
    if (got.size() != n) begin
      err_total++;
      $display("BAD %0t entry count", $time);
      stop_test;
    end
  endtask : wait_n
  task automatic take(input logic [3:0] c, input logic [63:3] a, input logic [2:0] l);
    prd_pkg::prd_req_s g;
    logic [5:0]        n;
    logic              sp;
    g  = got.pop_front();
    sp = c == prd_pkg::CMD_FLUSH || c == prd_pkg::CMD_FENCE;
    n  = {3'h0, l} + 6'h01;
    if (c[3] && !c[2] && !c[1]) n = n << 2;
    if (sp) n = {5'h00, c == prd_pkg::CMD_FLUSH};
    chk(64'(g.kind), 64'({sp, c[2]}), "kind");
    chk(64'(g.high_priority), 64'(c[0]), "priority");
    chk(64'(g.long_read), 64'(c[3] & !c[2] & !c[1]), "long");
    chk(64'(g.addr), sp ? 64'h0 : 64'(a), "address");
    chk(64'(g.qw_count), 64'(n), "count");
    if (!fresh) chk(64'(g.seq), 64'(lseq + 8'h01), "order");
    lseq  = g.seq;
    fresh = 1'b0;
  endtask : take
  task automatic t_cmds;
    logic [3:0] c[9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hc, 4'h0};
    fresh = 1'b1;
    foreach (c[i]) u_prd_master.req(c[i], 29'(i * 3 + 1), 3'(i), i == 8);
    wait_n(9);
    foreach (c[i]) take(c[i], 61'(i * 3 + 1), 3'(i));
  endtask : t_cmds
  task automatic t_dac;
    fresh = 1'b1;
    u_prd_master.dac(prd_pkg::CMD_RD_HP, 61'h1_2345_6789_abcd, 3'h7, 1'b0);
    u_prd_master.req(prd_pkg::CMD_LRD, 29'h100, 3'h7, 1'b1);
    wait_n(2);
    take(prd_pkg::CMD_RD_HP, 61'h1_2345_6789_abcd, 3'h7);
    take(prd_pkg::CMD_LRD, 61'h100, 3'h7);
  endtask : t_dac
  task automatic t_rsv;
    logic [3:0] r[7] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hb, 4'he, 4'hf};
    nerr = 0;
    foreach (r[i]) u_prd_master.req(r[i], 29'h40, 3'h0, 1'b1);
    sb <= 1'b1;
    u_prd_master.req(prd_pkg::CMD_DUAL, 29'h40, 3'h0, 1'b1);
    repeat (8) @(posedge clk);
    sb <= 1'b0;
    chk(64'(nerr), 64'h8, "error pulses");
    chk(64'(got.size()), 64'h0, "dropped");
  endtask : t_rsv
  task automatic t_stall;
    fresh = 1'b1;
    rdy  <= 1'b0;
    for (int i = 0; i < 3; i++) u_prd_master.req(prd_pkg::CMD_WR, 29'(i + 32), 3'h1, i == 2);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(64'(stall), 64'h1, "full");
    @(posedge clk);
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
    @(posedge clk);
    rdy <= 1'b1;
    wait_n(3);
    for (int i = 0; i < 3; i++) take(prd_pkg::CMD_WR, 61'(i + 32), 3'h1);
  endtask : t_stall
  task automatic t_slots;
    @(negedge clk);
    chk(64'(slots), 64'd13, "slots held");
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
    end
    @(negedge clk);
    chk(64'(slots), 64'h0, "slots freed");
  endtask : t_slots
  initial begin
    rstn = 1'b0;
    sb   = 1'b0;
    rdy  = 1'b1;
    ret  = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(64'({vld, stall, slots}), 64'h0, "reset state");
    @(posedge clk);
    t_cmds;
    t_dac;
    t_rsv;
    t_stall;
    t_slots;
    stop_test;
  end
endmodule : tb
bind prd_top prd_chk u_prd_chk (.I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN),
  .I_PIPE_N(I_PIPE_N), .I_CBE_N(I_CBE_N), .I_SLOT_RETIRE(I_SLOT_RETIRE),
  .I_REQ_READY(I_REQ_READY), .O_REQ_VALID(O_REQ_VALID), .O_REQ_KIND(O_REQ_KIND),
  .O_REQ_LONG(O_REQ_LONG), .O_REQ_ADDR(O_REQ_ADDR), .O_REQ_QW_COUNT(O_REQ_QW_COUNT),
  .O_REQ_SEQ(O_REQ_SEQ), .O_REQ_STALL(O_REQ_STALL), .O_SLOTS_USED(O_SLOTS_USED),
  .O_PROTOCOL_ERROR(O_PROTOCOL_ERROR));
`default_nettype wire
